// >>> mcr_consts.svh
/*
 * Offsets, field positions and reset values of the channel control register.
 * Assumes it is included by bare name from mcr_pkg users; definitions only.
 */
`ifndef MCR_CONSTS_SVH
`define MCR_CONSTS_SVH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define MCR_CTRL_OFFSET 8'h00
`define MCR_DATA_W 32
`define MCR_LANE_W 8
`define MCR_LANES 4

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define MCR_RUN_STOP_BIT 0
`define MCR_FIXED_ONE_BIT 1
`define MCR_SOFT_RESET_BIT 2
`define MCR_COMPLETE_EN_BIT 12
`define MCR_DELAY_EN_BIT 13
`define MCR_ERROR_EN_BIT 14

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define MCR_CTRL_RESET 32'h0000_0002
`define MCR_BIT_CLEAR 1'h0

`endif

// >>> mcr_pkg.sv
/*
 * Types shared by the channel control register and its halt sequencer.
 * Assumes nothing of its surroundings.
 */
package mcr_pkg;

    // ------------------------------------------------------------
    // Channel sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_HALTED = 3'h0,
        ST_RUNNING = 3'h1,
        ST_STOPPING = 3'h2,
        ST_RST_DRAIN = 3'h3,
        ST_RST_APPLY = 3'h4
    } mcr_state_t;

endpackage

// >>> mcr_halt_seq.sv
/*
 * Run, stop and soft reset sequencer of the memory to stream channel.
 * Assumes engine_idle and sg_update_busy come from engine logic on clk.
 */
`timescale 1ns/1ns

module mcr_halt_seq
    import mcr_pkg::*;
#(
    parameter bit gather_mode_param = 1'b1
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Requests from the control register
    input wire logic run_stop,
    input wire logic reset_req,
    // Engine progress
    input wire logic engine_idle,
    input wire logic sg_update_busy,
    // Sequencer results
    output logic halted,
    output logic run_active,
    output logic flush_req,
    output logic engine_reset
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mcr_state_t state_reg; // Current state
    mcr_state_t state_next; // Next state
    logic halted_reg; // Halted flag
    logic halted_next; // Next halted flag
    logic drained; // Nothing left in flight

    // Idle engine and, in gather mode, empty update queue
    assign drained = engine_idle && !(gather_mode_param && sg_update_busy);

    // Next state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_HALTED:
            begin
                if (reset_req)
                    state_next = ST_RST_DRAIN;
                else if (run_stop)
                    state_next = ST_RUNNING;
            end
            ST_RUNNING:
            begin
                if (reset_req)
                    state_next = ST_RST_DRAIN;
                else if (!run_stop)
                    state_next = ST_STOPPING;
            end
            ST_STOPPING:
            begin
                if (reset_req)
                    state_next = ST_RST_DRAIN;
                else if (drained)
                    state_next = ST_HALTED;
            end
            ST_RST_DRAIN:
            begin
                if (drained)
                    state_next = ST_RST_APPLY;
            end
            ST_RST_APPLY:
                state_next = ST_HALTED;
            default:
                state_next = ST_HALTED;
        endcase
        halted_next = (state_next == ST_HALTED);
    end

    // State registers
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_reg <= ST_HALTED;
            halted_reg <= 1'h1;
        end
        else
        begin
            state_reg <= state_next;
            halted_reg <= halted_next;
        end
    end

    // Outputs decoded from state; halted from its own register, loaded from next state
    assign halted = halted_reg;
    assign run_active = (state_reg == ST_RUNNING);
    assign flush_req = (state_reg == ST_STOPPING) || (state_reg == ST_RST_DRAIN);
    assign engine_reset = (state_reg == ST_RST_APPLY);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_drained_stop;
        (state_reg == ST_STOPPING) && drained && !reset_req;
    endsequence

    chk_halt_after_drain: assert property (s_drained_stop |=> halted)
        else $error("halted not set after drained stop");
    chk_stop_waits_idle: assert property (
        (state_reg == ST_STOPPING) && !engine_idle |=> !halted)
        else $error("halted before engine idle");
    chk_sg_queue_drain: assert property (
        (state_reg == ST_STOPPING) && gather_mode_param && sg_update_busy
        |=> !halted)
        else $error("halted with updates queued");
    chk_run_clears_halt: assert property (
        halted && run_stop && !reset_req |=> !halted ##0 run_active)
        else $error("halted kept after run");
    chk_cut_during_reset: assert property (
        reset_req && !engine_reset |=> flush_req || engine_reset)
        else $error("no flush during reset drain");

endmodule

// >>> mcr_control_reg.sv
/*
 * Memory to stream channel control register, low half, with run/stop,
 * graceful soft reset of the whole engine and interrupt enables.
 * Assumes a same-clock register port and engine status from logic on clk.
 */
`timescale 1ns/1ns
`include "mcr_consts.svh"

// How it works
// - Run/stop cleared: finish work, then stop
// - Gather mode: queued descriptor updates finish first
// - Stop or reset may cut stream short
// - Halted flag set once engine stopped
// - Channel error clears run/stop by hardware
// - Run starts engine, halted flag drops
// - Bit 1 ignores writes, reads one
// - Reset bit starts graceful whole-engine reset
// - Either channel's reset bit resets both
// - Reset bit reads one while resetting
// - Bits 11 to 3 read zero
// - Bit 12 gates completion interrupt
// - Bit 13 gates delay interrupt, gather only
// - Bit 14 gates error interrupt
// - Bit 15 reads zero, ignores writes
// - Little endian byte lanes, byte 0 low

module mcr_control_reg
    import mcr_pkg::*;
#(
    parameter bit gather_mode_param = 1'b1
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Engine status
    input wire logic engine_idle,
    input wire logic sg_update_busy,
    input wire logic channel_error,
    input wire logic stream_to_mem_reset,
    // Status flags feeding the interrupt
    input wire logic complete_irq_flag,
    input wire logic delay_irq_flag,
    input wire logic error_irq_flag,
    // Channel control results
    output logic run_stop,
    output logic halted,
    output logic run_active,
    output logic flush_req,
    output logic soft_reset_active,
    output logic engine_reset,
    output logic irq_out
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (`MCR_DATA_W != `MCR_LANE_W * `MCR_LANES)
    begin : g_bad_width
        $error("lane layout does not fill the data word");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Byte lane owning a bit, little endian
    function automatic logic lane_on(input logic [3:0] be, input int bitpos);
        lane_on = be[bitpos / `MCR_LANE_W];
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic wr_hit; // Write to control word
    logic rd_hit; // Read of control word
    logic run_stop_reg; // Run/stop bit
    logic run_stop_next;
    logic soft_reset_reg; // Reset in progress bit
    logic soft_reset_next;
    logic complete_en_reg; // Completion interrupt enable
    logic complete_en_next;
    logic delay_en_reg; // Delay interrupt enable
    logic delay_en_next;
    logic error_en_reg; // Error interrupt enable
    logic error_en_next;
    logic [31:0] rdata_reg; // Read data
    logic [31:0] rdata_next;
    logic rvalid_reg; // Read data valid
    logic rvalid_next;
    logic irq_reg; // Interrupt output
    logic irq_next;
    logic seq_engine_reset; // Reset pulse from sequencer
    localparam logic [31:0] ctrl_reset_val = `MCR_CTRL_RESET; // Reset image of the word

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    always_comb
    begin
        wr_hit = 1'h0;
        rd_hit = 1'h0;
        if (reg_addr == `MCR_CTRL_OFFSET)
        begin
            wr_hit = reg_wr_en;
            rd_hit = reg_rd_en;
        end
        else
        begin
            // Unmapped: writes dropped, reads return zero
            wr_hit = 1'h0;
            rd_hit = 1'h0;
        end
    end

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------

    // Next values of the writable fields
    always_comb
    begin
        run_stop_next = run_stop_reg;
        soft_reset_next = soft_reset_reg;
        complete_en_next = complete_en_reg;
        delay_en_next = delay_en_reg;
        error_en_next = error_en_reg;
        if (seq_engine_reset)
        begin
            // Soft reset done: every field back to reset value
            run_stop_next = `MCR_BIT_CLEAR;
            soft_reset_next = `MCR_BIT_CLEAR;
            complete_en_next = `MCR_BIT_CLEAR;
            delay_en_next = `MCR_BIT_CLEAR;
            error_en_next = `MCR_BIT_CLEAR;
        end
        else
        begin
            // Byte 0: run/stop and reset; bit 1 not stored
            if (wr_hit && lane_on(reg_be, `MCR_RUN_STOP_BIT))
            begin
                run_stop_next = reg_wdata[`MCR_RUN_STOP_BIT];
                if (reg_wdata[`MCR_SOFT_RESET_BIT])
                    soft_reset_next = 1'h1;
            end
            // Byte 1: interrupt enables; bits 11:3 and 15 not stored
            if (wr_hit && lane_on(reg_be, `MCR_COMPLETE_EN_BIT))
            begin
                complete_en_next = reg_wdata[`MCR_COMPLETE_EN_BIT];
                delay_en_next = reg_wdata[`MCR_DELAY_EN_BIT];
                error_en_next = reg_wdata[`MCR_ERROR_EN_BIT];
            end
            // Error stops the channel, wins over a write
            if (channel_error)
                run_stop_next = 1'h0;
        end
        // Other channel's reset sets the bit, even in the clearing cycle
        if (stream_to_mem_reset)
            soft_reset_next = 1'h1;
    end

    // Field registers
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            run_stop_reg <= ctrl_reset_val[`MCR_RUN_STOP_BIT];
            soft_reset_reg <= ctrl_reset_val[`MCR_SOFT_RESET_BIT];
            complete_en_reg <= ctrl_reset_val[`MCR_COMPLETE_EN_BIT];
            delay_en_reg <= ctrl_reset_val[`MCR_DELAY_EN_BIT];
            error_en_reg <= ctrl_reset_val[`MCR_ERROR_EN_BIT];
        end
        else
        begin
            run_stop_reg <= run_stop_next;
            soft_reset_reg <= soft_reset_next;
            complete_en_reg <= complete_en_next;
            delay_en_reg <= delay_en_next;
            error_en_reg <= error_en_next;
        end
    end

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------

    // Read data, assembled little endian
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        rvalid_next = reg_rd_en;
        if (rd_hit)
        begin
            rdata_next[`MCR_RUN_STOP_BIT] = run_stop_reg;
            rdata_next[`MCR_FIXED_ONE_BIT] = 1'h1;
            rdata_next[`MCR_SOFT_RESET_BIT] = soft_reset_reg;
            rdata_next[`MCR_COMPLETE_EN_BIT] = complete_en_reg;
            rdata_next[`MCR_DELAY_EN_BIT] = delay_en_reg;
            rdata_next[`MCR_ERROR_EN_BIT] = error_en_reg;
            // Bits 11:3, 15 and above stay zero
        end
    end

    // Read registers
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rdata_reg <= 32'h0000_0000;
            rvalid_reg <= 1'h0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ------------------------------------------------------------
    // Interrupt gating
    // ------------------------------------------------------------

    // Enabled flags onto one output
    always_comb
    begin
        irq_next = (complete_en_reg && complete_irq_flag)
            || (gather_mode_param && delay_en_reg && delay_irq_flag)
            || (error_en_reg && error_irq_flag);
    end

    // Interrupt register
    always_ff @(posedge clk)
    begin
        if (!nrst)
            irq_reg <= 1'h0;
        else
            irq_reg <= irq_next;
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    mcr_halt_seq #(
        .gather_mode_param(gather_mode_param)
    ) u_seq (
        .clk(clk),
        .nrst(nrst),
        .run_stop(run_stop_reg),
        .reset_req(soft_reset_reg),
        .engine_idle(engine_idle),
        .sg_update_busy(sg_update_busy),
        .halted(halted),
        .run_active(run_active),
        .flush_req(flush_req),
        .engine_reset(seq_engine_reset)
    );

    // Outputs
    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign run_stop = run_stop_reg;
    assign soft_reset_active = soft_reset_reg;
    assign engine_reset = seq_engine_reset;
    assign irq_out = irq_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_ctrl_read;
        reg_rd_en && (reg_addr == `MCR_CTRL_OFFSET);
    endsequence

    chk_error_stops_run: assert property (channel_error |=> !run_stop)
        else $error("run/stop kept after error");
    chk_fixed_one_read: assert property (s_ctrl_read |=> reg_rvalid && reg_rdata[1])
        else $error("bit 1 did not read one");
    chk_reserved_low: assert property (s_ctrl_read |=> reg_rdata[11:3] == 9'h000)
        else $error("bits 11:3 not zero");
    chk_reserved_b15: assert property (reg_rd_en |=> !reg_rdata[15])
        else $error("bit 15 not zero");
    chk_reset_clears: assert property (
        engine_reset && !stream_to_mem_reset |=> !soft_reset_active && !run_stop
        && !complete_en_reg && !delay_en_reg && !error_en_reg)
        else $error("fields not cleared after soft reset");
    chk_reset_visible: assert property (
        soft_reset_active && !engine_reset |=> soft_reset_active)
        else $error("reset bit dropped early");
    chk_other_reset: assert property (
        stream_to_mem_reset |=> soft_reset_active)
        else $error("other channel reset ignored");
    chk_irq_complete: assert property (
        complete_en_reg && complete_irq_flag |=> irq_out)
        else $error("completion interrupt not raised");
    chk_irq_error: assert property (
        error_en_reg && error_irq_flag |=> irq_out)
        else $error("error interrupt not raised");
    chk_irq_delay_gather: assert property (
        gather_mode_param && delay_en_reg && delay_irq_flag |=> irq_out)
        else $error("delay interrupt not raised");
    chk_irq_delay_simple: assert property (
        !gather_mode_param && !(complete_en_reg && complete_irq_flag)
        && !(error_en_reg && error_irq_flag) |=> !irq_out)
        else $error("delay interrupt in simple mode");
    chk_lane_write: assert property (
        reg_wr_en && (reg_addr == `MCR_CTRL_OFFSET) && !reg_be[0]
        && !channel_error && !engine_reset |=> $stable(run_stop))
        else $error("run/stop written without byte 0");

endmodule

// >>> mcr_control_reg_tb.sv
/*
 * Self-checking bench for the channel control register: register map,
 * byte lanes, interrupt gating, run/stop, error stop and soft resets.
 * Assumes the design files and mcr_consts.svh are compiled beforehand.
 */
`timescale 1ns/1ns

module mcr_control_reg_tb;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic clk = 1'b0; // Free running 50 MHz clock
    logic nrst = 1'b0; // Synchronous reset, active low
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [3:0] reg_be = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    logic engine_idle = 1'b1; // Engine quiet unless a test holds it busy
    logic sg_update_busy = 1'b0;
    logic channel_error = 1'b0;
    logic stream_to_mem_reset = 1'b0;
    logic [2:0] irq_flags = 3'h0; // Complete, delay, error flags
    logic run_stop, halted, run_active, flush_req;
    logic soft_reset_active, engine_reset, irq_out;
    int bad_count = 0;
    int checks_done = 0;
    int cycle_count = 0;

    // Clock generation, 10 ns half period
    always #10 clk = ~clk;

    // ------------------------------------------------------------
    // Design under test, gather mode
    // ------------------------------------------------------------
    mcr_control_reg #(.gather_mode_param(1'b1)) mcr_control_reg_inst
    (
        .clk(clk),
        .nrst(nrst),
        .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr),
        .reg_be(reg_be),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .engine_idle(engine_idle),
        .sg_update_busy(sg_update_busy),
        .channel_error(channel_error),
        .stream_to_mem_reset(stream_to_mem_reset),
        .complete_irq_flag(irq_flags[0]),
        .delay_irq_flag(irq_flags[1]),
        .error_irq_flag(irq_flags[2]),
        .run_stop(run_stop),
        .halted(halted),
        .run_active(run_active),
        .flush_req(flush_req),
        .soft_reset_active(soft_reset_active),
        .engine_reset(engine_reset),
        .irq_out(irq_out)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Verdict and end of run
    task automatic complete_run();
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Compare seen against expected
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", what, exp, seen);
            bad_count++;
        end
    endtask

    // Let n falling edges pass
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One write strobe, driven from a falling edge
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_be = be;
        reg_wdata = d;
        @(negedge clk);
        reg_wr_en = 1'b0;
        @(negedge clk); // Idle cycle keeps strobes of back to back calls apart
    endtask

    // One read strobe, answer one cycle later, then compare
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd_en = 1'b0;
        check("read valid", reg_rvalid, 32'h1);
        check("read data", reg_rdata, exp);
        @(negedge clk); // Idle cycle keeps strobes of back to back calls apart
    endtask

    // Wait, bounded, for engine_reset and then let it finish
    task automatic wait_engine_reset();
        for (int n = 0; n < 40 && engine_reset !== 1'b1; n++) @(negedge clk);
        check("engine reset pulse", engine_reset, 32'h1);
        settle(2);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset values, read-only bits and byte lanes
    task automatic test_map();
        rdchk(8'h00, 32'h0000_0002);
        check("halted after reset", halted, 32'h1);
        wr(8'h00, 4'hd, 32'hffff_7000); // Lane 1 disabled
        rdchk(8'h00, 32'h0000_0002);
        wr(8'h00, 4'hf, 32'hffff_8ff8); // Only reserved bits set
        rdchk(8'h00, 32'h0000_0002);
        wr(8'h00, 4'h2, 32'h0000_7000);
        rdchk(8'h00, 32'h0000_7002);
        wr(8'h04, 4'hf, 32'hffff_ffff); // Unmapped write ignored
        rdchk(8'h00, 32'h0000_7002);
        rdchk(8'h04, 32'h0000_0000);
        wr(8'h00, 4'h2, 32'h0000_0000);
    endtask

    // Each flag raises irq_out only once its own enable is set
    task automatic test_irq();
        for (int i = 0; i < 3; i++)
        begin
            irq_flags = 3'h1 << i;
            settle(3);
            check("irq disabled", irq_out, 32'h0);
            wr(8'h00, 4'h2, 32'h1 << (12 + i));
            settle(3);
            check("irq enabled", irq_out, 32'h1);
            irq_flags = 3'h0;
            settle(3);
            check("irq flag gone", irq_out, 32'h0);
            wr(8'h00, 4'h2, 32'h0);
        end
    endtask

    // Run, then stop with work and queued updates outstanding
    task automatic test_run_stop();
        wr(8'h00, 4'h1, 32'h1);
        settle(3);
        check("running", {halted, run_active}, 32'h1);
        engine_idle = 1'b0;
        sg_update_busy = 1'b1;
        wr(8'h00, 4'h1, 32'h0);
        settle(4);
        check("stopping", {run_stop, halted, flush_req}, 32'h1);
        engine_idle = 1'b1;
        settle(4);
        check("updates pending", halted, 32'h0);
        sg_update_busy = 1'b0;
        for (int n = 0; n < 10 && halted !== 1'b1; n++) @(negedge clk);
        check("halted", {halted, flush_req, run_active}, 32'h4);
    endtask

    // Channel error clears run/stop by itself
    task automatic test_error();
        wr(8'h00, 4'h1, 32'h1);
        settle(3);
        channel_error = 1'b1;
        @(negedge clk);
        channel_error = 1'b0;
        check("run cleared", run_stop, 32'h0);
        for (int n = 0; n < 10 && halted !== 1'b1; n++) @(negedge clk);
        check("halted after error", halted, 32'h1);
    endtask

    // Graceful soft reset from this channel's reset bit
    task automatic test_soft_reset();
        wr(8'h00, 4'h2, 32'h0000_7000);
        wr(8'h00, 4'h1, 32'h1);
        engine_idle = 1'b0;
        wr(8'h00, 4'h1, 32'h4);
        settle(1);
        rdchk(8'h00, 32'h0000_7006);
        wr(8'h00, 4'h1, 32'h5); // Run request during reset
        settle(3);
        check("reset in progress", {soft_reset_active, run_active}, 32'h2);
        engine_idle = 1'b1;
        wait_engine_reset();
        check("reset done", {soft_reset_active, run_stop, halted}, 32'h1);
        rdchk(8'h00, 32'h0000_0002);
    endtask

    // Other channel's reset bit resets this one too
    task automatic test_other_reset();
        wr(8'h00, 4'h2, 32'h0000_4000);
        stream_to_mem_reset = 1'b1;
        @(negedge clk);
        stream_to_mem_reset = 1'b0;
        settle(1);
        check("reset from other", soft_reset_active, 32'h1);
        wait_engine_reset();
        rdchk(8'h00, 32'h0000_0002);
    endtask

    // ------------------------------------------------------------
    // Hang guard
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 5000)
        begin
            bad_count++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        settle(1);
        test_map();
        test_irq();
        test_run_stop();
        test_error();
        test_soft_reset();
        test_other_reset();
        complete_run();
    end

endmodule
